// ---- design/snc_device.sv ----
module snc_device (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  snc_link_if.device link,
  // write-guard pin, low guards the status byte
  input wire logic write_guard_n,
  // decoded command report
  output logic cmd_strobe,
  output logic [7:0] cmd_opcode,
  output logic cmd_known,
  output logic cmd_write_granted,
  // status and protection
  output logic [7:0] status_byte,
  output logic protect_on,
  output logic [15:0] protect_floor
);

  typedef enum logic [1:0] {
    PH_OPCODE,
    PH_STATUS_OUT,
    PH_STATUS_IN,
    PH_IGNORE
  } snc_dev_phase_t;

  typedef struct packed {
    logic [2:0] sck_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic [1:0] guard_s;
    snc_dev_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] status;
    logic miso;
    logic miso_oe;
    logic strobe;
    logic [7:0] opcode;
    logic known;
    logic granted;
    logic prot_on;
    logic [15:0] prot_floor;
  } snc_dev_state_t;

  snc_dev_state_t st_reg;
  snc_dev_state_t st_next;

  function automatic logic is_known(input logic [7:0] op);
    case (op)
      snc_pkg::OP_LATCH_SET, snc_pkg::OP_LATCH_CLEAR, snc_pkg::OP_STATUS_READ,
      snc_pkg::OP_STATUS_WRITE, snc_pkg::OP_ARRAY_READ, snc_pkg::OP_ARRAY_WRITE,
      snc_pkg::OP_FAST_ARRAY_READ, snc_pkg::OP_DEVICE_CODE_READ,
      snc_pkg::OP_UNIQUE_CODE_READ, snc_pkg::OP_SERIAL_WRITE_ONCE,
      snc_pkg::OP_SERIAL_READ, snc_pkg::OP_SPECIAL_SECTOR_WRITE,
      snc_pkg::OP_SPECIAL_SECTOR_READ, snc_pkg::OP_FAST_SPECIAL_SECTOR_READ:
        is_known = 1'h1;
      default:
        is_known = 1'h0;
    endcase
  endfunction

  function automatic logic is_write_cmd(input logic [7:0] op);
    case (op)
      snc_pkg::OP_STATUS_WRITE, snc_pkg::OP_ARRAY_WRITE, snc_pkg::OP_SERIAL_WRITE_ONCE,
      snc_pkg::OP_SPECIAL_SECTOR_WRITE:
        is_write_cmd = 1'h1;
      default:
        is_write_cmd = 1'h0;
    endcase
  endfunction

  function automatic logic [15:0] floor_of(input logic [1:0] bp);
    case (bp)
      snc_pkg::BP_QUARTER:
        floor_of = snc_pkg::FLOOR_QUARTER;
      snc_pkg::BP_HALF:
        floor_of = snc_pkg::FLOOR_HALF;
      default:
        floor_of = snc_pkg::FLOOR_ALL;
    endcase
  endfunction

  logic sck_rise;
  logic sck_fall;
  logic latch_now;
  logic guard_block;
  logic [7:0] shifted;

  always_comb
  begin
    st_next = st_reg;
    st_next.strobe = 1'h0;
    st_next.sck_s = {st_reg.sck_s[1:0], link.sck};
    st_next.cs_s = {st_reg.cs_s[0], link.cs_n};
    st_next.mosi_s = {st_reg.mosi_s[0], link.mosi};
    st_next.guard_s = {st_reg.guard_s[0], write_guard_n};
    // edges seen only after both synchroniser stages
    sck_rise = st_reg.sck_s[1] & ~st_reg.sck_s[2];
    sck_fall = ~st_reg.sck_s[1] & st_reg.sck_s[2];
    latch_now = st_reg.status[snc_pkg::ST_LATCH];
    guard_block = st_reg.status[snc_pkg::ST_GUARD_EN] & ~st_reg.guard_s[1];
    shifted = {st_reg.shift[6:0], st_reg.mosi_s[1]};
    if (st_reg.cs_s[1])
    begin
      // deselected: partial op-code or data is dropped
      st_next.phase = PH_OPCODE;
      st_next.bit_cnt = 3'h0;
      st_next.miso_oe = 1'h0;
    end
    else if (sck_rise)
    begin
      case (st_reg.phase)
        PH_OPCODE:
        begin
          st_next.shift = shifted;
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
          if (st_reg.bit_cnt == snc_pkg::BYTE_LAST_BIT)
          begin
            st_next.bit_cnt = 3'h0;
            st_next.strobe = 1'h1;
            st_next.opcode = shifted;
            st_next.known = is_known(shifted);
            st_next.granted = is_write_cmd(shifted) & latch_now;
            st_next.phase = PH_IGNORE;
            case (shifted)
              snc_pkg::OP_LATCH_SET:
                st_next.status[snc_pkg::ST_LATCH] = 1'h1;
              snc_pkg::OP_LATCH_CLEAR:
                st_next.status[snc_pkg::ST_LATCH] = 1'h0;
              snc_pkg::OP_STATUS_READ:
                st_next.phase = PH_STATUS_OUT;
              snc_pkg::OP_STATUS_WRITE:
              begin
                st_next.granted = latch_now & ~guard_block;
                if (latch_now && !guard_block)
                begin
                  st_next.phase = PH_STATUS_IN;
                end
              end
              default:
              begin
              end
            endcase
          end
        end
        PH_STATUS_IN:
        begin
          st_next.shift = shifted;
          st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
          if (st_reg.bit_cnt == snc_pkg::BYTE_LAST_BIT)
          begin
            // latch bit kept, bit 0 forced low, latch left set
            st_next.status = (st_reg.status & ~snc_pkg::ST_WRITABLE_MASK)
              | (shifted & snc_pkg::ST_WRITABLE_MASK);
            st_next.status[snc_pkg::ST_ZERO] = 1'h0;
            st_next.bit_cnt = 3'h0;
            st_next.phase = PH_IGNORE;
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (sck_fall && st_reg.phase == PH_STATUS_OUT)
    begin
      // repeated status bytes while the clock keeps running
      st_next.miso = st_reg.status[~st_reg.bit_cnt];
      st_next.miso_oe = 1'h1;
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
    end
    st_next.prot_on = st_next.status[snc_pkg::ST_BP_HI:snc_pkg::ST_BP_LO]
      != snc_pkg::BP_NONE;
    st_next.prot_floor = floor_of(st_next.status[snc_pkg::ST_BP_HI:snc_pkg::ST_BP_LO]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.sck_s <= 3'h0;
      st_reg.cs_s <= 2'h3;
      st_reg.guard_s <= 2'h3;
      st_reg.phase <= PH_OPCODE;
      // nonvolatile bits take their preset, the latch starts clear
      st_reg.status <= snc_pkg::ST_RESET & snc_pkg::ST_WRITABLE_MASK;
      st_reg.prot_floor <= snc_pkg::FLOOR_ALL;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign link.miso_o = st_reg.miso;
  assign link.miso_oe = st_reg.miso_oe;
  assign cmd_strobe = st_reg.strobe;
  assign cmd_opcode = st_reg.opcode;
  assign cmd_known = st_reg.known;
  assign cmd_write_granted = st_reg.granted;
  assign status_byte = st_reg.status;
  assign protect_on = st_reg.prot_on;
  assign protect_floor = st_reg.prot_floor;

endmodule // snc_device

// ---- design/snc_host.sv ----
module snc_host #(
  parameter int HALF_CYC = snc_pkg::LINK_HALF_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  snc_link_if.host link,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_SHIFT,
    HS_GAP
  } snc_host_phase_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
    logic [1:0] miso_s;
    snc_host_phase_t phase;
    logic [7:0] div;
    logic [4:0] bits;
    logic [4:0] total;
    logic [15:0] tx;
    logic [7:0] rx;
    logic [7:0] rx_byte;
    logic [31:0] cmd;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } snc_host_state_t;

  snc_host_state_t st_reg;
  snc_host_state_t st_next;
  logic [31:0] merged;
  logic half_done;

  always_comb
  begin
    st_next = st_reg;
    st_next.miso_s = {st_reg.miso_s[0], link.miso};
    half_done = st_reg.div == 8'(HALF_CYC - 1);
    for (int i = 0; i < 4; i++)
    begin
      merged[i * 8 +: 8] = s_axi_wstrb[i] ? s_axi_wdata[i * 8 +: 8] : st_reg.cmd[i * 8 +: 8];
    end
    // write channel: ready raised once both address and data wait
    if (st_reg.awready)
    begin
      st_next.awready = 1'h0;
      st_next.wready = 1'h0;
      st_next.bvalid = 1'h1;
      st_next.bresp = snc_pkg::RESP_SLVERR;
      if (s_axi_awaddr == snc_pkg::REG_CMD)
      begin
        st_next.bresp = snc_pkg::RESP_OKAY;
        st_next.cmd = merged;
        // a command written while busy is stored in the command register but never sent
        if (st_reg.phase == HS_IDLE)
        begin
          st_next.cs_n = 1'h0;
          st_next.tx = merged[snc_pkg::CMD_OP_LSB +: 16];
          st_next.mosi = merged[snc_pkg::CMD_OP_LSB + 7];
          st_next.total = merged[snc_pkg::CMD_LEN_LSB +: 2] == snc_pkg::LEN_OP_ONLY
            ? snc_pkg::BITS_SHORT : snc_pkg::BITS_LONG;
          st_next.tx = {merged[snc_pkg::CMD_OP_LSB +: 8], merged[snc_pkg::CMD_DATA_LSB +: 8]};
          st_next.bits = 5'h00;
          st_next.div = 8'h00;
          st_next.phase = HS_SHIFT;
        end
      end
    end
    else if (!st_reg.bvalid && s_axi_awvalid && s_axi_wvalid)
    begin
      st_next.awready = 1'h1;
      st_next.wready = 1'h1;
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'h0;
    end
    // read channel
    if (st_reg.arready)
    begin
      st_next.arready = 1'h0;
      st_next.rvalid = 1'h1;
      st_next.rresp = snc_pkg::RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      if (s_axi_araddr == snc_pkg::REG_CMD)
      begin
        st_next.rdata = st_reg.cmd;
      end
      else if (s_axi_araddr == snc_pkg::REG_STAT)
      begin
        st_next.rdata[snc_pkg::STAT_BUSY_BIT] = st_reg.phase != HS_IDLE;
        st_next.rdata[snc_pkg::STAT_RX_LSB +: 8] = st_reg.rx_byte;
      end
      else
      begin
        st_next.rresp = snc_pkg::RESP_SLVERR;
      end
    end
    else if (!st_reg.rvalid && s_axi_arvalid)
    begin
      st_next.arready = 1'h1;
    end
    if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'h0;
    end
    // serial engine, mode 0
    case (st_reg.phase)
      HS_SHIFT:
      begin
        st_next.div = half_done ? 8'h00 : st_reg.div + 8'h01;
        if (half_done && !st_reg.sck)
        begin
          st_next.sck = 1'h1;
          st_next.rx = {st_reg.rx[6:0], st_reg.miso_s[1]};
        end
        else if (half_done)
        begin
          st_next.sck = 1'h0;
          if (st_reg.bits == st_reg.total - 5'h01)
          begin
            st_next.cs_n = 1'h1;
            st_next.rx_byte = st_reg.rx;
            st_next.phase = HS_GAP;
          end
          else
          begin
            st_next.bits = st_reg.bits + 5'h01;
            st_next.tx = {st_reg.tx[14:0], 1'h0};
            st_next.mosi = st_reg.tx[14];
          end
        end
      end
      HS_GAP:
      begin
        st_next.div = st_reg.div + 8'h01;
        if (half_done)
        begin
          st_next.phase = HS_IDLE;
        end
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.cs_n <= 1'h1;
      st_reg.phase <= HS_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign link.sck = st_reg.sck;
  assign link.cs_n = st_reg.cs_n;
  assign link.mosi = st_reg.mosi;
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;

endmodule // snc_host

// ---- design/snc_link_if.sv ----
interface snc_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // undriven data line reads low
  assign miso = miso_oe ? miso_o : 1'h0;

  modport host (
    output sck,
    output cs_n,
    output mosi,
    input miso
  );

  modport device (
    input sck,
    input cs_n,
    input mosi,
    output miso_o,
    output miso_oe
  );
endinterface

// ---- design/snc_pkg.sv ----
package snc_pkg;

  // op-codes, shifted in most significant bit first
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_FAST_ARRAY_READ = 8'h0B;
  localparam logic [7:0] OP_DEVICE_CODE_READ = 8'h9F;
  localparam logic [7:0] OP_UNIQUE_CODE_READ = 8'h4C;
  localparam logic [7:0] OP_SERIAL_WRITE_ONCE = 8'hC2;
  localparam logic [7:0] OP_SERIAL_READ = 8'hC3;
  localparam logic [7:0] OP_SPECIAL_SECTOR_WRITE = 8'h42;
  localparam logic [7:0] OP_SPECIAL_SECTOR_READ = 8'h4B;
  localparam logic [7:0] OP_FAST_SPECIAL_SECTOR_READ = 8'h49;
  localparam logic [7:0] OP_RESERVED_A = 8'hCE;
  localparam logic [7:0] OP_RESERVED_B = 8'hCF;
  localparam logic [7:0] OP_RESERVED_C = 8'hCC;

  // protection status byte layout
  localparam int ST_GUARD_EN = 7;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam int ST_LATCH = 1;
  localparam int ST_ZERO = 0;
  localparam logic [7:0] ST_WRITABLE_MASK = 8'hFC;
  localparam logic [7:0] ST_RESET = 8'h00;

  // block-protect floors
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [15:0] FLOOR_QUARTER = 16'hC000;
  localparam logic [15:0] FLOOR_HALF = 16'h8000;
  localparam logic [15:0] FLOOR_ALL = 16'h0000;

  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // host register map
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_LEN_LSB = 16;
  localparam logic [1:0] LEN_OP_ONLY = 2'h0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RX_LSB = 8;
  localparam logic [4:0] BITS_SHORT = 5'h08;
  localparam logic [4:0] BITS_LONG = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // serial clock timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

endpackage

// ---- verification/snc_link_sva.sv ----
module snc_link_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link wires
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic cs_q;
  logic [4:0] rise_reg;
  // sck rises since the last select, kept after the frame ends
  always_ff @(posedge aclk)
  begin
    sck_q <= sck;
    cs_q <= cs_n;
    if (!aresetn || (cs_q && !cs_n))
      rise_reg <= 5'h00;
    else if (sck && !sck_q)
      rise_reg <= rise_reg + 5'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_idle_sck;
    cs_n |-> !sck;
  endproperty
  a_idle_sck: assert property (p_idle_sck)
    else $error("sck high while deselected");
  property p_sck_high;
    $rose(sck) |-> sck [*8];
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("sck high phase too short");
  property p_first_edge;
    $fell(cs_n) |-> !sck [*8] ##[1:4] sck;
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("first sck rise misplaced after select");
  property p_mosi_hold;
    sck |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi moved while sck high");
  property p_frame_len;
    $rose(cs_n) |-> (rise_reg == 5'h08 || rise_reg == 5'h10);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame not 8 or 16 clocks");
  property p_oe_release;
    $rose(cs_n) |-> ##[0:6] !miso_oe;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("miso still driven after deselect");
  property p_miso_hold;
    miso_oe && sck |-> $stable(miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso moved while sck high");
  property p_oe_after_op;
    $rose(miso_oe) |-> rise_reg >= 5'h08;
  endproperty
  a_oe_after_op: assert property (p_oe_after_op)
    else $error("miso driven before op-code complete");
  c_status_out: cover property ($rose(miso_oe));
  c_short_frame: cover property ($rose(cs_n) && rise_reg == 5'h08);
  c_long_frame: cover property ($rose(cs_n) && rise_reg == 5'h10);
endmodule // snc_link_sva

// ---- verification/test_spi_nvram_command_status.sv ----
module test_spi_nvram_command_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, guard_n;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cmd_strobe, cmd_known, cmd_write_granted, protect_on, strobe2;
  logic [7:0] cmd_opcode, status_byte, status2, rx;
  logic [15:0] protect_floor;
  logic [31:0] seed;
  int err_total, n_compared, n_strobe2, st, latch;
  // defined op-codes only, the reserved ones are never sent
  logic [7:0] ops[$] = '{8'h06, 8'h02, 8'hC2, 8'h42, 8'h01, 8'h04, 8'h02, 8'h01, 8'h05,
    8'h03, 8'h0B, 8'h9F, 8'h4C, 8'hC3, 8'h4B, 8'h49};
  snc_link_if link();
  snc_link_if link2();
  snc_host snc_host_inst (.aclk, .aresetn, .link(link), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  snc_device snc_device_inst (.aclk, .aresetn, .link(link), .write_guard_n(guard_n),
    .cmd_strobe, .cmd_opcode, .cmd_known, .cmd_write_granted, .status_byte, .protect_on,
    .protect_floor);
  snc_device snc_device_inst2 (.aclk, .aresetn, .link(link2), .write_guard_n(1'b1),
    .cmd_strobe(strobe2), .cmd_opcode(), .cmd_known(), .cmd_write_granted(),
    .status_byte(status2), .protect_on(), .protect_floor());
  snc_link_sva snc_link_sva_inst (.aclk, .aresetn, .sck(link.sck), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
    if (strobe2 === 1'b1)
      n_strobe2++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    $display("BAD %0t wait ran out", $time);
    results();
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    if (n == 200)
      timeout();
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    if (n == 200)
      timeout();
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er, "rresp");
  endtask
  // one command through the host, then the model is stepped and compared
  task automatic run_cmd(input logic [7:0] op, input logic [7:0] d, input logic [1:0] len);
    int n, bp, grd;
    axi_wr(4'h0, {14'h0000, len, d, op}, 2'h0);
    for (n = 0; n < 200; n++)
    begin
      axi_rd(4'h4, 2'h0, r);
      if (r[0] === 1'b0)
        break;
    end
    if (n == 200)
      timeout();
    rx = r[15:8];
    grd = st[7] && !guard_n;
    chk(cmd_opcode, op, "opcode");
    chk(cmd_known, op inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02, 8'h0B, 8'h9F, 8'h4C,
      8'hC2, 8'hC3, 8'h42, 8'h4B, 8'h49}, "known");
    chk(cmd_write_granted, (op inside {8'h02, 8'h01, 8'hC2, 8'h42}) && latch
      && !(op == 8'h01 && grd), "grant");
    if (op == 8'h06)
      latch = 1;
    if (op == 8'h04)
      latch = 0;
    if (op == 8'h01 && len != 0 && latch && !grd)
      st = d & 8'hFC;
    if (op == 8'h05 && len != 0)
      chk(rx, st | (latch << 1), "status read");
    bp = st[3:2];
    chk(status_byte, st | (latch << 1), "status");
    chk(protect_on, bp != 0, "protect on");
    chk(protect_floor, bp == 1 ? 16'hC000 : bp == 2 ? 16'h8000 : 16'h0000, "floor");
  endtask
  // second device driven directly, so a frame can be cut short; cpol high runs mode 3
  task automatic bang(input logic [7:0] op, input int nb, input logic cpol);
    int i;
    n_strobe2 = 0;
    @(posedge aclk);
    link2.sck <= cpol;
    repeat (10) @(posedge aclk);
    link2.cs_n <= 1'h0;
    for (i = 0; i < nb; i++)
    begin
      repeat (10) @(posedge aclk);
      link2.sck <= 1'h0;
      link2.mosi <= op[7 - i];
      repeat (10) @(posedge aclk);
      link2.sck <= 1'h1;
    end
    repeat (10) @(posedge aclk);
    link2.sck <= cpol;
    repeat (10) @(posedge aclk);
    link2.cs_n <= 1'h1;
    link2.mosi <= ~link2.mosi;
    repeat (20) @(posedge aclk);
  endtask
  initial
  begin
    aresetn = 1'b0;
    guard_n = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    link2.cs_n = 1'b1;
    link2.sck = 1'b0;
    link2.mosi = 1'b0;
    {err_total, n_compared, st, latch} = '0;
    seed = 32'h24D6;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(status_byte, 8'h00, "reset status");
    chk(protect_on, 1'b0, "reset protect");
    $display("test reset done");
    axi_wr(4'h8, 32'h0, 2'h2);
    axi_rd(4'h8, 2'h2, r);
    chk(r, 32'h0, "unmapped read");
    $display("test unmapped done");
    foreach (ops[i])
    begin
      seed = lfsr(seed);
      run_cmd(ops[i], seed[7:0], 2'h0);
    end
    $display("test op-code table done");
    run_cmd(8'h04, 8'h00, 2'h0);
    run_cmd(8'h01, 8'hFF, 2'h1);
    run_cmd(8'h06, 8'h00, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      run_cmd(8'h01, (seed[7:0] & 8'h73) | 8'(i << 2), 2'h1);
      run_cmd(8'h05, 8'h00, 2'h1);
    end
    $display("test status write done");
    run_cmd(8'h01, 8'h8C, 2'h1);
    guard_n <= 1'b0;
    repeat (4) @(posedge aclk);
    run_cmd(8'h01, 8'h00, 2'h1);
    guard_n <= 1'b1;
    repeat (4) @(posedge aclk);
    run_cmd(8'h01, 8'h00, 2'h1);
    $display("test guard done");
    bang(8'h06, 7, 1'h0);
    chk(n_strobe2, 0, "abort strobe");
    chk(status2, 8'h00, "abort status");
    bang(8'h06, 8, 1'h0);
    chk(n_strobe2, 1, "strobe");
    chk(status2, 8'h02, "latch set");
    bang(8'h04, 8, 1'h0);
    chk(status2, 8'h00, "latch clear");
    bang(8'h06, 8, 1'h1);
    chk(n_strobe2, 1, "mode 3 strobe");
    chk(status2, 8'h02, "mode 3 latch set");
    bang(8'h04, 8, 1'h1);
    chk(status2, 8'h00, "mode 3 latch clear");
    $display("test abort done");
    results();
  end
endmodule // test_spi_nvram_command_status
